// ==== rtl/uart_irq_modem_ctrl.sv ====
// interrupt, modem control and character registers of a serial controller
// Functional notes
// - identity bit 0 reads low while an enabled interrupt pends, else high
// - identity bits 2:1 give the code of the highest pending interrupt
// - priority: line status 11, rx data 10, tx empty 01, modem 00
// - reading identity freezes the top interrupt until it is serviced
// - identity bits 7:3 always read zero
// - each source reaches the irq output only while its enable bit is set
// - enable bits: 0 rx data, 1 tx empty, 2 line status, 3 modem
// - enable bits 7:4 always read zero
// - status keeps updating while interrupts are disabled
// - terminal-ready pin is low when modem control bit 0 is one
// - bits 1,2,3 drive request-to-send, aux 1, aux 2 the same inverted way
// - loopback: serial out at mark, rx pin ignored, tx shift fed to rx
// - loopback: modem status 7:4 follow aux2, aux1, terminal, rts
// - loopback: modem interrupts come from control bits, still enabled
// - writing ones to modem status bits 3:0 raises the modem interrupt
// - modem control bits 7:5 always read zero
// - deltas 0,1,3 set on input change; any status read clears all four except a bit that changes in that same cycle
// - delta bit 2 sets only on ring going from on to off
// - any delta bit set raises the modem status interrupt
// - outside loopback status 7:4 are complements of the four inputs
// - base read with select bit zero returns received char, read only
// - base write with select bit zero loads char to send, write only
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_defs.svh"

module uart_irq_modem_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        divisor_select_bit,
    input  wire logic        line_status_irq,
    input  wire logic        rx_data_ready,
    input  wire logic        tx_holding_empty,
    input  wire logic        rx_load,
    input  wire logic [7:0]  rx_char,
    output logic             rx_read,
    output logic             tx_load,
    output logic      [7:0]  tx_char,
    input  wire logic        tx_shift_out,
    input  wire logic        serial_rx_pin,
    output logic             serial_tx_pin,
    output logic             rx_shift_in,
    input  wire logic        clear_to_send_n,
    input  wire logic        set_ready_n,
    input  wire logic        ring_n,
    input  wire logic        line_detect_n,
    output logic             terminal_ready_n,
    output logic             request_to_send_n,
    output logic             aux_out1_n,
    output logic             aux_out2_n,
    output logic             irq_output
);

    // ---------------- bus slave ----------------
    logic        acc;
    logic        rd_acc;
    logic [9:0]  a_idx;
    logic        wr_pend_r,  wr_pend_nxt;
    logic [9:0]  wr_idx_r,   wr_idx_nxt;
    logic [31:0] hrdata_r,   hrdata_nxt;
    logic        hready_r;
    logic [7:0]  rd_byte;

    // ---------------- control state ----------------
    logic [7:0]  mc_r,       mc_nxt;
    logic [7:0]  ie_r,       ie_nxt;
    logic [7:0]  rbuf_r,     rbuf_nxt;
    logic [7:0]  tx_char_r,  tx_char_nxt;
    logic        tx_load_r,  tx_load_nxt;
    logic        rx_read_r,  rx_read_nxt;
    logic [3:0]  delta_r,    delta_nxt;
    logic        primed_r,   primed_nxt;
    logic        txe_prev_r, txe_prev_nxt;
    logic        tx_pend_r,  tx_pend_nxt;
    logic        frozen_r,   frozen_nxt;
    logic        irq_r,      irq_nxt;
    logic        serial_tx_pin_r,     serial_tx_pin_nxt;
    logic        sin_r,      sin_nxt;
    logic [3:0]  pins_n_r,   pins_n_nxt;
    uart_irq_pkg::irq_id_t      frz_id_r, frz_id_nxt;
    uart_irq_pkg::modem_lines_t prev_r,   prev_nxt;
    uart_irq_pkg::modem_lines_t stat_now;
    uart_irq_pkg::irq_src_t     src;
    uart_irq_pkg::irq_src_t     gated;
    uart_irq_pkg::irq_id_t      live_id;
    uart_irq_pkg::irq_id_t      shown_id;
    logic        any_pend;
    logic        frz_live;
    logic [3:0]  delta_set;
    logic        loop;
    logic        sel0;
    logic        rd_iir, rd_msr, rd_rbr;
    logic        wr_thr, wr_ier, wr_mcr, wr_msr;

    assign acc    = hsel & htrans[`TRANS_BUSY_BIT] & hready;
    assign rd_acc = acc & ~hwrite;
    assign a_idx  = haddr[`IDX_MSB:`IDX_LSB];
    assign loop   = mc_r[`MC_LOOP];
    assign sel0   = ~divisor_select_bit;

    assign rd_iir = rd_acc & (a_idx == `IRQ_ID_IDX);
    assign rd_msr = rd_acc & (a_idx == `MDM_STAT_IDX);
    assign rd_rbr = rd_acc & (a_idx == `RX_BUF_IDX) & sel0;
    assign wr_thr = wr_pend_r & (wr_idx_r == `RX_BUF_IDX) & sel0;
    assign wr_ier = wr_pend_r & (wr_idx_r == `IRQ_EN_IDX) & sel0;
    assign wr_mcr = wr_pend_r & (wr_idx_r == `MDM_CTL_IDX);
    assign wr_msr = wr_pend_r & (wr_idx_r == `MDM_STAT_IDX);

    // current modem line state as software sees it
    always_comb begin
        if (loop) begin
            stat_now.clear_to_send = mc_r[`MC_RTS];
            stat_now.set_ready     = mc_r[`MC_TERM];
            stat_now.ring          = mc_r[`MC_AUX1];
            stat_now.line_detect   = mc_r[`MC_AUX2];
        end else begin
            stat_now.clear_to_send = ~clear_to_send_n;
            stat_now.set_ready     = ~set_ready_n;
            stat_now.ring          = ~ring_n;
            stat_now.line_detect   = ~line_detect_n;
        end
    end

    // change detection; nothing is flagged before the first sample
    always_comb begin
        delta_set[0] = primed_r &
                       (stat_now.clear_to_send ^ prev_r.clear_to_send);
        delta_set[1] = primed_r &
                       (stat_now.set_ready ^ prev_r.set_ready);
        delta_set[2] = primed_r & prev_r.ring & ~stat_now.ring;
        delta_set[3] = primed_r &
                       (stat_now.line_detect ^ prev_r.line_detect);
    end

    always_comb begin
        src.line     = line_status_irq;
        src.rx_data  = rx_data_ready;
        src.tx_empty = tx_pend_r;
        src.modem    = |delta_r;
    end

    irq_identify u_ident (
        .enable   (ie_r[3:0]),
        .src      (src),
        .any_pend (any_pend),
        .top_id   (live_id),
        .gated    (gated)
    );

    // a frozen code holds while its own source still pends
    always_comb begin
        unique case (frz_id_r)
            uart_irq_pkg::ID_LINE:     frz_live = gated.line;
            uart_irq_pkg::ID_RX_DATA:  frz_live = gated.rx_data;
            uart_irq_pkg::ID_TX_EMPTY: frz_live = gated.tx_empty;
            uart_irq_pkg::ID_MODEM:    frz_live = gated.modem;
        endcase
        shown_id = (frozen_r && frz_live) ? frz_id_r : live_id;
    end

    // read data, captured in the address phase
    always_comb begin
        rd_byte = 8'h00;
        unique case (a_idx)
            `RX_BUF_IDX:   rd_byte = sel0 ? rbuf_r : 8'h00;
            `IRQ_EN_IDX:   rd_byte = sel0 ? (ie_r & `IE_MASK) : 8'h00;
            `IRQ_ID_IDX:   rd_byte = {5'h00, shown_id, ~any_pend};
            `MDM_CTL_IDX:  rd_byte = mc_r & `MC_MASK;
            `MDM_STAT_IDX: rd_byte = {stat_now, delta_r};
            default:       rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        wr_pend_nxt = acc & hwrite;
        wr_idx_nxt  = a_idx;
        hrdata_nxt  = rd_acc ? {24'h000000, rd_byte} : 32'h00000000;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 10'h000;
            hrdata_r  <= 32'h00000000;
            hready_r  <= 1'b0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_idx_r  <= wr_idx_nxt;
            hrdata_r  <= hrdata_nxt;
            hready_r  <= 1'b1;
        end
    end

    // ---------------- next control state ----------------
    always_comb begin
        mc_nxt       = wr_mcr ? (hwdata[7:0] & `MC_MASK) : mc_r;
        ie_nxt       = wr_ier ? (hwdata[7:0] & `IE_MASK) : ie_r;
        rbuf_nxt     = rx_load ? rx_char : rbuf_r;
        tx_char_nxt  = wr_thr ? hwdata[7:0] : tx_char_r;
        tx_load_nxt  = wr_thr;
        rx_read_nxt  = rd_rbr;
        primed_nxt   = 1'b1;
        prev_nxt     = stat_now;
        txe_prev_nxt = tx_holding_empty;
        // deltas: read clears, write ones sets, a new change always wins
        delta_nxt = (rd_msr ? 4'h0 : delta_r)
                  | (wr_msr ? hwdata[3:0] : 4'h0)
                  | delta_set;
        tx_pend_nxt = tx_pend_r;
        if (wr_thr || (rd_iir && any_pend &&
                       shown_id == uart_irq_pkg::ID_TX_EMPTY)) begin
            tx_pend_nxt = 1'b0;
        end
        if (tx_holding_empty && !txe_prev_r) begin
            tx_pend_nxt = 1'b1;
        end
        frozen_nxt = frozen_r && frz_live;
        frz_id_nxt = frz_id_r;
        if (rd_iir && any_pend && !(frozen_r && frz_live)) begin
            frozen_nxt = 1'b1;
            frz_id_nxt = live_id;
        end
        irq_nxt  = any_pend;
        serial_tx_pin_nxt = loop ? `MARK_LEVEL : tx_shift_out;
        sin_nxt  = loop ? tx_shift_out : serial_rx_pin;
        pins_n_nxt = ~mc_r[3:0];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_r       <= `MC_RST;
            ie_r       <= `IE_RST;
            rbuf_r     <= 8'h00;
            tx_char_r  <= 8'h00;
            tx_load_r  <= 1'b0;
            rx_read_r  <= 1'b0;
            delta_r    <= 4'h0;
            primed_r   <= 1'b0;
            prev_r     <= '0;
            txe_prev_r <= 1'b0;
            tx_pend_r  <= 1'b0;
            frozen_r   <= 1'b0;
            frz_id_r   <= uart_irq_pkg::ID_MODEM;
            irq_r      <= 1'b0;
            serial_tx_pin_r     <= `MARK_LEVEL;
            sin_r      <= `MARK_LEVEL;
            pins_n_r   <= {4{`PIN_IDLE_N}};
        end else begin
            mc_r       <= mc_nxt;
            ie_r       <= ie_nxt;
            rbuf_r     <= rbuf_nxt;
            tx_char_r  <= tx_char_nxt;
            tx_load_r  <= tx_load_nxt;
            rx_read_r  <= rx_read_nxt;
            delta_r    <= delta_nxt;
            primed_r   <= primed_nxt;
            prev_r     <= prev_nxt;
            txe_prev_r <= txe_prev_nxt;
            tx_pend_r  <= tx_pend_nxt;
            frozen_r   <= frozen_nxt;
            frz_id_r   <= frz_id_nxt;
            irq_r      <= irq_nxt;
            serial_tx_pin_r     <= serial_tx_pin_nxt;
            sin_r      <= sin_nxt;
            pins_n_r   <= pins_n_nxt;
        end
    end

    assign hrdata            = hrdata_r;
    assign hreadyout         = hready_r;
    assign hresp             = 1'b0;
    assign rx_read           = rx_read_r;
    assign tx_load           = tx_load_r;
    assign tx_char           = tx_char_r;
    assign serial_tx_pin     = serial_tx_pin_r;
    assign rx_shift_in       = sin_r;
    assign terminal_ready_n  = pins_n_r[`MC_TERM];
    assign request_to_send_n = pins_n_r[`MC_RTS];
    assign aux_out1_n        = pins_n_r[`MC_AUX1];
    assign aux_out2_n        = pins_n_r[`MC_AUX2];
    assign irq_output        = irq_r;

    // ---------------- checks ----------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence read_iir_s;
        rd_iir;
    endsequence

    sequence read_ier_s;
        rd_acc && a_idx == `IRQ_EN_IDX;
    endsequence

    sequence write_mcr_s;
        wr_mcr;
    endsequence

    iir_pend_bit_a:
    assert property (read_iir_s |=> hrdata[0] == !$past(any_pend))
        else $error("identity bit 0 does not match pending state");

    iir_high_zero_a:
    assert property (read_iir_s |=> hrdata[7:3] == 5'h00)
        else $error("identity upper bits not zero");

    line_top_prio_a:
    assert property (gated.line && !frozen_r |-> shown_id == 2'b11)
        else $error("line status not reported first");

    ier_high_zero_a:
    assert property (read_ier_s |=> hrdata[7:4] == 4'h0)
        else $error("enable upper bits not zero");

    irq_disabled_a:
    assert property (ie_r[3:0] == 4'h0 |=> !irq_output)
        else $error("irq raised with all enables clear");

    irq_follows_a:
    assert property (##1 irq_output == $past(|gated))
        else $error("irq output does not follow gated sources");

    term_pin_a:
    assert property (write_mcr_s |-> ##2
                     terminal_ready_n == !$past(hwdata[0], 2))
        else $error("terminal-ready pin not inverted from control bit");

    loop_mark_a:
    assert property (loop |=> serial_tx_pin == 1'b1)
        else $error("serial out not at mark in loopback");

    msr_clear_a:
    assert property (rd_msr && delta_set == 4'h0 |=> delta_r == 4'h0)
        else $error("delta bits not cleared by status read");

    ring_fall_a:
    assert property ($rose(delta_r[2]) |-> $past(prev_r.ring && !stat_now.ring
                     || wr_msr && hwdata[2]))
        else $error("ring delta set without falling ring");

    tx_write_a:
    assert property (wr_thr |=> tx_load && tx_char == $past(hwdata[7:0]))
        else $error("transmit character not loaded");

endmodule : uart_irq_modem_ctrl

`default_nettype wire

// ==== inc/uart_irq_defs.svh ====
// register indices, bit positions and reset values of the irq/modem block
`ifndef UART_IRQ_DEFS_SVH
`define UART_IRQ_DEFS_SVH

// register indices; byte address is four times the index
`define RX_BUF_IDX      10'h3F8
`define IRQ_EN_IDX      10'h3F9
`define IRQ_ID_IDX      10'h3FA
`define MDM_CTL_IDX     10'h3FC
`define MDM_STAT_IDX    10'h3FE
`define IDX_MSB         11
`define IDX_LSB         2
`define TRANS_BUSY_BIT  1

// interrupt enable bits
`define EN_RX           0
`define EN_TX           1
`define EN_LINE         2
`define EN_MODEM        3

// modem control bits
`define MC_TERM         0
`define MC_RTS          1
`define MC_AUX1         2
`define MC_AUX2         3
`define MC_LOOP         4

// implemented bits and reset values
`define MC_MASK         8'h1F
`define IE_MASK         8'h0F
`define MC_RST          8'h00
`define IE_RST          8'h00
`define MARK_LEVEL      1'b1
`define PIN_IDLE_N      1'b1

`endif

// ==== inc/uart_irq_pkg.sv ====
// types shared by the irq/modem block and its priority encoder
`default_nettype none
package uart_irq_pkg;

    typedef enum logic [1:0] {
        ID_MODEM    = 2'b00,
        ID_TX_EMPTY = 2'b01,
        ID_RX_DATA  = 2'b10,
        ID_LINE     = 2'b11
    } irq_id_t;

    typedef struct packed {
        logic modem;
        logic line;
        logic tx_empty;
        logic rx_data;
    } irq_src_t;

    typedef struct packed {
        logic line_detect;
        logic ring;
        logic set_ready;
        logic clear_to_send;
    } modem_lines_t;

endpackage : uart_irq_pkg

`default_nettype wire

// ==== rtl/irq_identify.sv ====
// gates interrupt sources with their enables and picks the highest one
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_defs.svh"

module irq_identify (
    input  wire logic                 [3:0] enable,
    input  wire uart_irq_pkg::irq_src_t     src,
    output logic                            any_pend,
    output uart_irq_pkg::irq_id_t           top_id,
    output uart_irq_pkg::irq_src_t          gated
);

    always_comb begin
        gated.rx_data  = src.rx_data  & enable[`EN_RX];
        gated.tx_empty = src.tx_empty & enable[`EN_TX];
        gated.line     = src.line     & enable[`EN_LINE];
        gated.modem    = src.modem    & enable[`EN_MODEM];
        any_pend       = |gated;
        if (gated.line) begin
            top_id = uart_irq_pkg::ID_LINE;
        end else if (gated.rx_data) begin
            top_id = uart_irq_pkg::ID_RX_DATA;
        end else if (gated.tx_empty) begin
            top_id = uart_irq_pkg::ID_TX_EMPTY;
        end else begin
            top_id = uart_irq_pkg::ID_MODEM;
        end
    end

endmodule : irq_identify

`default_nettype wire

// ==== tb/modem_model.sv ====
// modem partner: active-low modem lines and a toggling serial stream
`timescale 1ns/1ps
`default_nettype none

module modem_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] lines_on,
    output logic            clear_to_send_n,
    output logic            set_ready_n,
    output logic            ring_n,
    output logic            line_detect_n,
    output logic            serial_rx_pin
);
    // lines follow the bench's request one edge later
    initial begin
        {line_detect_n, ring_n, set_ready_n, clear_to_send_n} = 4'hF;
        serial_rx_pin = 1'h1;
        forever begin
            @(posedge core_clk);
            {line_detect_n, ring_n, set_ready_n, clear_to_send_n} <= ~lines_on;
            serial_rx_pin <= ~serial_rx_pin;
        end
    end
endmodule : modem_model
`default_nettype wire

// ==== tb/uart_irq_modem_ctrl_test.sv ====
// self-checking bench for the irq/modem block
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_defs.svh"

module uart_irq_modem_ctrl_test;
    typedef struct packed {
        logic [2:0] src;
        logic       wr;
        logic [9:0] idx;
        logic [7:0] d;
        logic       irq;
    } row_t;
    logic        core_clk, rst_n, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0]  htrans;
    logic        divisor_select_bit, line_status_irq, rx_data_ready;
    logic        tx_holding_empty, rx_load, rx_read, tx_load, tx_shift_out;
    logic [7:0]  rx_char, tx_char;
    logic        serial_rx_pin, serial_tx_pin, rx_shift_in, irq_output;
    logic        clear_to_send_n, set_ready_n, ring_n, line_detect_n;
    logic        terminal_ready_n, request_to_send_n, aux_out1_n, aux_out2_n;
    logic [3:0]  lines_on;
    int          fail_count, samples_checked, cyc, n_rd, n_ld;
    row_t        rows [13];

    assign hready = hreadyout;
    uart_irq_modem_ctrl u_dut (
        .core_clk, .rst_n, .hsel(1'h1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .divisor_select_bit, .line_status_irq, .rx_data_ready,
        .tx_holding_empty, .rx_load, .rx_char, .rx_read, .tx_load,
        .tx_char, .tx_shift_out, .serial_rx_pin, .serial_tx_pin,
        .rx_shift_in, .clear_to_send_n, .set_ready_n, .ring_n,
        .line_detect_n, .terminal_ready_n, .request_to_send_n,
        .aux_out1_n, .aux_out2_n, .irq_output);
    modem_model u_modem (
        .core_clk, .lines_on, .clear_to_send_n, .set_ready_n, .ring_n,
        .line_detect_n, .serial_rx_pin);

    always #20 core_clk = ~core_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (rx_read === 1'h1)
            n_rd <= n_rd + 1;
        if (tx_load === 1'h1)
            n_ld <= n_ld + 1;
        if (cyc == 4000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [31:0] pins();
        return {28'h0, aux_out2_n, aux_out1_n, request_to_send_n,
                terminal_ready_n};
    endfunction : pins

    // one single AHB transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [9:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd_v);
        @(posedge core_clk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, idx, 2'h0};
        do @(posedge core_clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge core_clk); while (hready !== 1'h1);
        rd_v = hrdata;
    endtask : bus

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        bus(1'h1, idx, d, v);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        bus(1'h0, idx, 8'h00, v);
        chk($sformatf("reg %h", idx), {24'h0, e}, v);
        chk("hresp", 32'h0, hresp);
    endtask : rd

    task automatic settle();
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    task automatic set_lines(input logic [3:0] l);
        @(posedge core_clk);
        lines_on <= l;
        settle();
    endtask : set_lines

    initial begin
        core_clk = 1'h0;
        {rst_n, hwrite, divisor_select_bit, line_status_irq} = '0;
        {rx_data_ready, tx_holding_empty, rx_load, tx_shift_out} = '0;
        {haddr, hwdata, htrans, rx_char, lines_on} = '0;
        {fail_count, samples_checked, cyc, n_rd, n_ld} = '0;
        rows = '{
            '{3'h0, 1'h0, `IRQ_ID_IDX, 8'h01, 1'h0},
            '{3'h7, 1'h0, `IRQ_ID_IDX, 8'h01, 1'h0},
            '{3'h7, 1'h1, `IRQ_EN_IDX, 8'hFF, 1'h0},
            '{3'h7, 1'h0, `IRQ_EN_IDX, 8'h0F, 1'h1},
            '{3'h7, 1'h0, `IRQ_ID_IDX, 8'h06, 1'h1},
            '{3'h3, 1'h0, `IRQ_ID_IDX, 8'h04, 1'h1},
            '{3'h1, 1'h0, `IRQ_ID_IDX, 8'h02, 1'h1},
            '{3'h1, 1'h0, `IRQ_ID_IDX, 8'h01, 1'h0},
            '{3'h7, 1'h1, `IRQ_EN_IDX, 8'h01, 1'h1},
            '{3'h7, 1'h0, `IRQ_ID_IDX, 8'h04, 1'h1},
            '{3'h0, 1'h0, 10'h3FB, 8'h00, 1'h0},
            '{3'h0, 1'h1, `IRQ_ID_IDX, 8'hFF, 1'h0},
            '{3'h0, 1'h0, `IRQ_ID_IDX, 8'h01, 1'h0}};
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1;
        @(negedge core_clk);
        chk("pins", 32'hF, pins());
        chk("serial_tx_pin", 32'h1, serial_tx_pin);
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge core_clk);
            {line_status_irq, rx_data_ready, tx_holding_empty} <= rows[i].src;
            settle();
            chk("irq_output", rows[i].irq, irq_output);
            if (rows[i].wr)
                wr(rows[i].idx, rows[i].d);
            else
                rd(rows[i].idx, rows[i].d);
        end
        $display("test rows done");
        for (int k = 0; k < 4; k++) begin
            wr(`MDM_CTL_IDX, 8'h01 << k);
            settle();
            chk("pins", ~(32'h1 << k) & 32'hF, pins());
        end
        wr(`MDM_CTL_IDX, 8'hEF);
        rd(`MDM_CTL_IDX, 8'h0F);
        wr(`MDM_CTL_IDX, 8'h00);
        wr(`IRQ_EN_IDX, 8'h08);
        rd(`MDM_STAT_IDX, 8'h00);
        set_lines(4'h1);
        chk("irq_output", 32'h1, irq_output);
        rd(`IRQ_ID_IDX, 8'h00);
        rd(`MDM_STAT_IDX, 8'h11);
        rd(`MDM_STAT_IDX, 8'h10);
        settle();
        chk("irq_output", 32'h0, irq_output);
        set_lines(4'h5);
        rd(`MDM_STAT_IDX, 8'h50);
        set_lines(4'h1);
        rd(`MDM_STAT_IDX, 8'h14);
        set_lines(4'hB);
        rd(`MDM_STAT_IDX, 8'hBA);
        wr(`MDM_STAT_IDX, 8'h04);
        settle();
        chk("irq_output", 32'h1, irq_output);
        rd(`MDM_STAT_IDX, 8'hB4);
        wr(`IRQ_EN_IDX, 8'h00);
        set_lines(4'hA);
        chk("irq_output", 32'h0, irq_output);
        rd(`MDM_STAT_IDX, 8'hA1);
        wr(`MDM_STAT_IDX, 8'h01);
        wr(`IRQ_EN_IDX, 8'h0F);
        rd(`IRQ_ID_IDX, 8'h00);
        @(posedge core_clk);
        line_status_irq <= 1'h1;
        settle();
        rd(`IRQ_ID_IDX, 8'h00);
        rd(`MDM_STAT_IDX, 8'hA1);
        rd(`IRQ_ID_IDX, 8'h06);
        @(posedge core_clk);
        line_status_irq <= 1'h0;
        wr(`IRQ_EN_IDX, 8'h00);
        $display("test modem status done");
        wr(`MDM_CTL_IDX, 8'h13);
        set_lines(4'h0);
        rd(`MDM_STAT_IDX, 8'h39);
        wr(`IRQ_EN_IDX, 8'h08);
        wr(`MDM_CTL_IDX, 8'h17);
        wr(`MDM_CTL_IDX, 8'h13);
        settle();
        chk("irq_output", 32'h1, irq_output);
        rd(`MDM_STAT_IDX, 8'h34);
        for (int b = 0; b < 2; b++) begin
            @(posedge core_clk);
            tx_shift_out <= b[0];
            settle();
            chk("serial_tx_pin", 32'h1, serial_tx_pin);
            chk("rx_shift_in", b, rx_shift_in);
        end
        wr(`IRQ_EN_IDX, 8'h00);
        wr(`MDM_CTL_IDX, 8'h00);
        @(posedge core_clk);
        tx_shift_out <= 1'h0;
        settle();
        chk("serial_tx_pin", 32'h0, serial_tx_pin);
        chk("rx_shift_in", !serial_rx_pin, rx_shift_in);
        rd(`MDM_STAT_IDX, 8'h03);
        $display("test loopback done");
        @(posedge core_clk);
        rx_char <= 8'hA5;
        rx_load <= 1'h1;
        @(posedge core_clk);
        rx_load <= 1'h0;
        rd(`RX_BUF_IDX, 8'hA5);
        wr(`RX_BUF_IDX, 8'h3C);
        settle();
        chk("tx_char", 32'h3C, tx_char);
        rd(`RX_BUF_IDX, 8'hA5);
        @(negedge core_clk);
        chk("pulses", 32'h21, {n_rd[3:0], n_ld[3:0]});
        @(posedge core_clk);
        divisor_select_bit <= 1'h1;
        rd(`RX_BUF_IDX, 8'h00);
        wr(`IRQ_EN_IDX, 8'h0F);
        @(posedge core_clk);
        divisor_select_bit <= 1'h0;
        rd(`IRQ_EN_IDX, 8'h00);
        $display("test characters done");
        wr(`MDM_CTL_IDX, 8'h0F);
        settle();
        chk("pins", 32'h0, pins());
        @(posedge core_clk);
        rst_n <= 1'h0;
        @(negedge core_clk);
        chk("pins", 32'hF, pins());
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1;
        rd(`MDM_CTL_IDX, 8'h00);
        $display("test second reset done");
        finish_test();
    end
endmodule : uart_irq_modem_ctrl_test
`default_nettype wire
